/* File: rtl/pcb_decode.sv */
// decoder of one control word into port-C and interrupt-enable actions
// assumes the current mode word from the same clock domain
`default_nettype none
module pcb_decode
  import pcb_pkg::*;
(
  input  wire logic [7:0] cmdWord,
  input  wire logic [7:0] modeWord,
  output logic            isModeWord,
  output logic [7:0]      portCMask,
  output logic            setValue,
  output logic [2:0]      irqSel,
  output logic            irqHit
);
  function automatic pcb_mode_t groupAMode(input logic [7:0] m);
    if (m[ModeAHi]) begin
      groupAMode = PcbModeBidir;
    end else if (m[ModeALo]) begin
      groupAMode = PcbModeStrobed;
    end else begin
      groupAMode = PcbModeBasic;
    end
  endfunction

  logic [2:0] idx;
  pcb_mode_t  modeA;
  assign idx        = cmdWord[CmdIdxLo +: 3];
  assign isModeWord = cmdWord[CmdModeBit];
  assign setValue   = cmdWord[CmdValBit];
  assign modeA      = groupAMode(modeWord);

  always_comb begin
    portCMask = 8'h00;
    irqSel    = 3'h0;
    irqHit    = 1'b0;
    if (!isModeWord) begin
      portCMask = 8'h01 << idx;
      if (idx == IdxGroupB && modeWord[ModeBBit]) begin
        irqSel = 3'h1;
        irqHit = 1'b1;
      end else if (idx == IdxGroupAIn && modeA == PcbModeStrobed && modeWord[ModeADirBit]) begin
        irqSel = 3'h2;
        irqHit = 1'b1;
      end else if (idx == IdxGroupAIn && modeA == PcbModeBidir) begin
        irqSel = 3'h3;
        irqHit = 1'b1;
      end else if (idx == IdxGroupAOut && modeA == PcbModeStrobed && !modeWord[ModeADirBit]) begin
        irqSel = 3'h2;
        irqHit = 1'b1;
      end else if (idx == IdxGroupAOut && modeA == PcbModeBidir) begin
        irqSel = 3'h4;
        irqHit = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pcb_irq.sv */
// sticky event status with enable mask and one level interrupt
// assumes events are single-cycle pulses on the same clock
`default_nettype none
module pcb_irq
  import pcb_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic [EvCount-1:0]  events,
  input  wire logic [EvCount-1:0]  clearBits,
  input  wire logic                enableWr,
  input  wire logic [EvCount-1:0]  enableData,
  output logic      [EvCount-1:0]  status,
  output logic      [EvCount-1:0]  enable,
  output logic                     irq
);
  logic [EvCount-1:0] status_q;
  logic [EvCount-1:0] enable_q;
  logic               irq_q;

  // set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      status_q <= IrqReset;
    end else begin
      status_q <= (status_q & ~clearBits) | events;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      enable_q <= IrqReset;
    end else if (enableWr) begin
      enable_q <= enableData;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((status_q & ~clearBits) | events) & (enableWr ? enableData : enable_q));
    end
  end

  assign status = status_q;
  assign enable = enable_q;
  assign irq    = irq_q;
endmodule
`default_nettype wire

/* File: rtl/pcb_pkg.sv */
// package for the port-C bit set/reset block: register map, fields, modes
// assumes a single 100 MHz clock domain and a 32-bit Avalon-MM slave bus
package pcb_pkg;
  localparam int          DataW         = 32;
  localparam int          AddrW         = 4;
  // byte addresses of word registers
  localparam logic [3:0]  OffCommand    = 4'h0;
  localparam logic [3:0]  OffPortC      = 4'h4;
  localparam logic [3:0]  OffIrqStatus  = 4'h8;
  localparam logic [3:0]  OffIrqEnable  = 4'hc;
  // irq clear sits at the status offset on writes
  localparam logic [3:0]  OffIrqClear   = 4'h8;
  // command word fields
  localparam int          CmdModeBit    = 7;
  localparam int          CmdIdxLo      = 1;
  localparam int          CmdValBit     = 0;
  // mode word fields
  localparam int          ModeAHi       = 6;
  localparam int          ModeALo       = 5;
  localparam int          ModeADirBit   = 4;
  localparam int          ModeBBit      = 2;
  localparam int          ModeBDirBit   = 1;
  // port-C bit indices that double as interrupt-enable selectors
  localparam logic [2:0]  IdxGroupB     = 3'h2;
  localparam logic [2:0]  IdxGroupAIn   = 3'h4;
  localparam logic [2:0]  IdxGroupAOut  = 3'h6;
  // reset values
  localparam logic [7:0]  PortCReset    = 8'h00;
  localparam logic [7:0]  ModeReset     = 8'h9b;
  localparam logic [3:0]  IrqReset      = 4'h0;
  // status event bit positions
  localparam int          EvBitCmd      = 0;
  localparam int          EvModeWord    = 1;
  localparam int          EvEnableSet   = 2;
  localparam int          EvIgnored     = 3;
  localparam int          EvCount       = 4;
  typedef enum logic [1:0] {PcbModeBasic, PcbModeStrobed, PcbModeBidir} pcb_mode_t;
endpackage

/* File: rtl/pcb_top.sv */
// port-C bit set/reset and interrupt-enable control, Avalon-MM slave
// assumes one clock, synchronous active-low reset, 32-bit word accesses
`default_nettype none
module pcb_top
  import pcb_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic [pcb_pkg::AddrW-1:0] avsAddress,
  input  wire logic                    avsRead,
  input  wire logic                    avsWrite,
  input  wire logic [pcb_pkg::DataW-1:0] avsWritedata,
  input  wire logic [3:0]              avsByteenable,
  output logic      [pcb_pkg::DataW-1:0] avsReaddata,
  output logic                         avsWaitrequest,
  output logic      [7:0]              portCOut,
  output logic                         groupBIrqEnable,
  output logic                         groupAIrqEnable,
  output logic                         bidirInIrqEnable,
  output logic                         bidirOutIrqEnable,
  output logic                         irqOut
);
  import pcb_pkg::*;

  logic [DataW-1:0]   readdata_q;
  logic               ack_q;
  logic [7:0]         portC_q;
  logic [7:0]         mode_q;
  logic               enB_q;
  logic               enA_q;
  logic               enIn_q;
  logic               enOut_q;
  logic               cmdWrite;
  logic [7:0]         cmdByte;
  logic               isModeWord;
  logic [7:0]         portCMask;
  logic               setValue;
  logic [2:0]         irqSel;
  logic               irqHit;
  logic [EvCount-1:0] events;
  logic [EvCount-1:0] clearBits;
  logic               enableWr;
  logic [EvCount-1:0] status;
  logic [EvCount-1:0] enable;
  logic               irq;
  logic               wait_q;

  // one wait cycle per access: the request is taken when ack_q is high
  assign cmdWrite = avsWrite & ack_q & (avsAddress == OffCommand) & avsByteenable[0];
  assign cmdByte  = avsWritedata[7:0];
  assign enableWr = avsWrite & ack_q & (avsAddress == OffIrqEnable) & avsByteenable[0];
  assign clearBits = (avsWrite & ack_q & (avsAddress == OffIrqClear) & avsByteenable[0])
                     ? avsWritedata[EvCount-1:0] : {EvCount{1'b0}};

  pcb_decode u_decode (
    .cmdWord    (cmdByte),
    .modeWord   (mode_q),
    .isModeWord (isModeWord),
    .portCMask  (portCMask),
    .setValue   (setValue),
    .irqSel     (irqSel),
    .irqHit     (irqHit)
  );

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avsRead | avsWrite) & ~ack_q;
    end
  end

  // registered wait, always the inverse of ack_q
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((avsRead | avsWrite) & ~ack_q);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      readdata_q <= '0;
    end else if (avsRead & ~ack_q) begin
      unique case (avsAddress)
        OffPortC:     readdata_q <= {24'h000000, portC_q};
        OffIrqStatus: readdata_q <= {{(DataW-EvCount){1'b0}}, status};
        OffIrqEnable: readdata_q <= {{(DataW-EvCount){1'b0}}, enable};
        OffCommand:   readdata_q <= {24'h000000, mode_q};
        default:      readdata_q <= '0;
      endcase
    end
  end

  // mode word stored for enable routing
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mode_q <= ModeReset;
    end else if (cmdWrite && isModeWord) begin
      mode_q <= cmdByte;
    end
  end

  // only the addressed bit changes
  always_ff @(posedge clock) begin
    if (!resetn) begin
      portC_q <= PortCReset;
    end else if (cmdWrite && !isModeWord) begin
      portC_q <= (portC_q & ~portCMask) | (portCMask & {8{setValue}});
    end
  end

  // each flag is written only when its selector matches
  always_ff @(posedge clock) begin
    if (!resetn) begin
      enB_q   <= 1'b0;
      enA_q   <= 1'b0;
      enIn_q  <= 1'b0;
      enOut_q <= 1'b0;
    end else if (cmdWrite && irqHit) begin
      unique case (irqSel)
        3'h1:    enB_q   <= setValue;
        3'h2:    enA_q   <= setValue;
        3'h3:    enIn_q  <= setValue;
        3'h4:    enOut_q <= setValue;
        default: enB_q   <= enB_q;
      endcase
    end
  end

  assign events[EvBitCmd]    = cmdWrite & ~isModeWord;
  assign events[EvModeWord]  = cmdWrite & isModeWord;
  assign events[EvEnableSet] = cmdWrite & irqHit;
  assign events[EvIgnored]   = avsWrite & ack_q & ~avsByteenable[0];

  pcb_irq u_irq (
    .clock      (clock),
    .resetn     (resetn),
    .events     (events),
    .clearBits  (clearBits),
    .enableWr   (enableWr),
    .enableData (avsWritedata[EvCount-1:0]),
    .status     (status),
    .enable     (enable),
    .irq        (irq)
  );

  assign avsWaitrequest    = wait_q;
  assign avsReaddata       = readdata_q;
  assign portCOut          = portC_q;
  assign groupBIrqEnable   = enB_q;
  assign groupAIrqEnable   = enA_q;
  assign bidirInIrqEnable  = enIn_q;
  assign bidirOutIrqEnable = enOut_q;
  assign irqOut            = irq;
endmodule
`default_nettype wire

/* File: test/pcb_host.sv */
// host model: Avalon-MM master issuing single word accesses
// assumes the slave answers by dropping waitrequest
`default_nettype none
module pcb_host
  import pcb_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             avsWaitrequest,
  input  wire logic [DataW-1:0] avsReaddata,
  output logic      [AddrW-1:0] avsAddress,
  output logic                  avsRead,
  output logic                  avsWrite,
  output logic      [DataW-1:0] avsWritedata,
  output logic      [3:0]       avsByteenable
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {avsAddress, avsRead, avsWrite, avsWritedata, avsByteenable} = '0;
  end
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clock);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= d;
    avsByteenable <= be;
    do @(posedge clock); while (avsWaitrequest);
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    // released lines show no stale value
    avsWritedata <= ~d;
    avsAddress <= ~a;
  endtask
endmodule
`default_nettype wire

/* File: test/pcb_top_asserts.sv */
// assertions for the port-C bit command block, bound to its top module
// assumes one clock and a synchronous active-low reset
`default_nettype none
module pcb_top_asserts
  import pcb_pkg::*;
(
  input wire logic             clock,
  input wire logic             resetn,
  input wire logic [AddrW-1:0] avsAddress,
  input wire logic             avsWrite,
  input wire logic [DataW-1:0] avsWritedata,
  input wire logic [3:0]       avsByteenable,
  input wire logic             avsWaitrequest,
  input wire logic [7:0]       portCOut,
  input wire logic             groupBIrqEnable,
  input wire logic             groupAIrqEnable,
  input wire logic             bidirInIrqEnable,
  input wire logic             bidirOutIrqEnable
);
  logic [7:0] mode_q;
  logic       wr;
  logic       bc;
  logic [2:0] ix;
  logic       v;
  assign wr = avsWrite && !avsWaitrequest && avsByteenable[0] && avsAddress == OffCommand;
  assign bc = wr && !avsWritedata[CmdModeBit];
  assign ix = avsWritedata[3:1];
  assign v = avsWritedata[CmdValBit];
  // shadow of the mode word
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mode_q <= ModeReset;
    end else if (wr && avsWritedata[CmdModeBit]) begin
      mode_q <= avsWritedata[7:0];
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_bit_drive: assert property (bc |=> portCOut[$past(ix)] == $past(v))
    else $error("port-C bit not driven");
  a_others_kept: assert property (bc |=>
    ((portCOut ^ $past(portCOut)) & ~(8'h01 << $past(ix))) == 8'h00)
    else $error("other port-C bits moved");
  a_mode_keeps_pins: assert property (wr && avsWritedata[7] |=> $stable(portCOut))
    else $error("mode word touched port C");
  a_group_b_flag: assert property (bc && ix == IdxGroupB && mode_q[2]
    |=> groupBIrqEnable == $past(v)) else $error("group B enable wrong");
  a_group_a_in: assert property (bc && ix == IdxGroupAIn && mode_q[6:4] == 3'b011
    |=> groupAIrqEnable == $past(v)) else $error("group A input enable wrong");
  a_group_a_out: assert property (bc && ix == IdxGroupAOut && mode_q[6:4] == 3'b010
    |=> groupAIrqEnable == $past(v)) else $error("group A output enable wrong");
  a_bidir_in: assert property (bc && ix == IdxGroupAIn && mode_q[6]
    |=> bidirInIrqEnable == $past(v)) else $error("bidir input enable wrong");
  a_bidir_out: assert property (bc && ix == IdxGroupAOut && mode_q[6]
    |=> bidirOutIrqEnable == $past(v)) else $error("bidir output enable wrong");
  c_bit_cmd: cover property (bc);
  c_mode_word: cover property (wr && avsWritedata[7]);
  c_bidir_cmd: cover property (bc && mode_q[6]);
endmodule
bind pcb_top pcb_top_asserts chkInst (.clock(clock), .resetn(resetn),
  .avsAddress(avsAddress), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
  .avsByteenable(avsByteenable), .avsWaitrequest(avsWaitrequest), .portCOut(portCOut),
  .groupBIrqEnable(groupBIrqEnable), .groupAIrqEnable(groupAIrqEnable),
  .bidirInIrqEnable(bidirInIrqEnable), .bidirOutIrqEnable(bidirOutIrqEnable));
`default_nettype wire

/* File: test/pcb_top_bench.sv */
// self-checking bench for the port-C bit command block
// assumes the host model and the bound checker compile alongside
`default_nettype none
module pcb_top_bench
  import pcb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clock = 1'b0;
  logic             resetn = 1'b0;
  logic [AddrW-1:0] avsAddress;
  logic             avsRead, avsWrite, avsWaitrequest, irqOut;
  logic [DataW-1:0] avsWritedata, avsReaddata, q;
  logic [3:0]       avsByteenable, fl;
  logic [7:0]       portCOut, md, pc;
  logic [7:0]       modes[5] = '{8'h80, 8'hb4, 8'hac, 8'hc4, 8'hc0};
  int               fails = 0;
  int               cmpCount = 0;
  int               f[4];
  always #5 clock = ~clock;
  pcb_top uut (.clock(clock), .resetn(resetn), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .portCOut(portCOut), .groupBIrqEnable(fl[0]),
    .groupAIrqEnable(fl[1]), .bidirInIrqEnable(fl[2]), .bidirOutIrqEnable(fl[3]),
    .irqOut(irqOut));
  pcb_host host (.clock(clock), .avsWaitrequest(avsWaitrequest),
    .avsReaddata(avsReaddata), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable));
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", fails, cmpCount);
    if (fails == 0 && cmpCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // control word through the bus, then compare with the model
  task automatic cmd(input logic [7:0] w);
    host.acc(1'b1, OffCommand, {24'h0, w}, 4'hf, q);
    if (w[7]) md = w;
    else begin
      pc[w[3:1]] = w[0];
      if (md[2] && w[3:1] == 3'd2) f[0] = w[0];
      if (md[6:5] == 2'b01 && w[3:1] == (md[4] ? 3'd4 : 3'd6)) f[1] = w[0];
      if (md[6] && w[3:1] == 3'd4) f[2] = w[0];
      if (md[6] && w[3:1] == 3'd6) f[3] = w[0];
    end
    @(posedge clock);
    #1;
    chk(32'(portCOut), 32'(pc));
    for (int i = 0; i < 4; i++) begin
      if (f[i] >= 0) chk(32'(fl[i]), f[i]);
    end
  endtask
  task automatic irqChk(input logic e);
    repeat (2) @(posedge clock);
    #1;
    chk(32'(irqOut), 32'(e));
  endtask
  initial begin
    pc = PortCReset;
    md = ModeReset;
    f = '{0, 0, 0, 0};
    void'($urandom(32'h8aab));
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    host.acc(1'b0, OffCommand, 32'h0, 4'hf, q);
    chk(q, 32'(ModeReset));
    host.acc(1'b0, OffPortC, 32'h0, 4'hf, q);
    chk(q, 32'(PortCReset));
    host.acc(1'b0, 4'h2, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    foreach (modes[i]) begin
      cmd(modes[i]);
      for (int k = 2; k < 7; k += 2) cmd(8'(k * 2 + 1));
      repeat (16) cmd(8'($urandom) & 8'h7f);
    end
    host.acc(1'b0, OffCommand, 32'h0, 4'hf, q);
    chk(q, 32'(md));
    host.acc(1'b1, OffIrqClear, 32'hf, 4'hf, q);
    host.acc(1'b1, OffIrqEnable, 32'h1, 4'hf, q);
    host.acc(1'b0, OffIrqEnable, 32'h0, 4'hf, q);
    chk(q, 32'h1);
    cmd(8'h0f);
    irqChk(1'b1);
    host.acc(1'b0, OffIrqStatus, 32'h0, 4'hf, q);
    chk(q, 32'h1);
    host.acc(1'b1, OffIrqClear, 32'h1, 4'hf, q);
    irqChk(1'b0);
    host.acc(1'b1, OffIrqEnable, 32'h0, 4'hf, q);
    cmd(8'h0e);
    irqChk(1'b0);
    host.acc(1'b1, OffCommand, 32'h0f, 4'h0, q);
    host.acc(1'b1, 4'h2, 32'h0f, 4'hf, q);
    host.acc(1'b0, OffIrqStatus, 32'h0, 4'hf, q);
    chk(q, 32'h9);
    chk(32'(portCOut), 32'(pc));
    final_report();
  end
  initial begin
    #50us;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
